// ### common/aie_defs.svh
`ifndef AIE_DEFS_SVH
`define AIE_DEFS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define AIE_NUM_IN     45
`define AIE_HI_BITS    13
`define AIE_ADDR_W     8

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define AIE_OFF_IEN_LO  8'h00
`define AIE_OFF_IEN_HI  8'h04
`define AIE_OFF_EST_LO  8'h08
`define AIE_OFF_EST_HI  8'h0c
`define AIE_OFF_EIEN_LO 8'h10
`define AIE_OFF_EIEN_HI 8'h14
`define AIE_OFF_EISEL   8'h18

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define AIE_SEL_W       3
`define AIE_SEL_C1_LSB  0
`define AIE_SEL_SH_LSB  4
`define AIE_RST_WORD    32'h0000_0000
`define AIE_RST_SEL     3'h0

`endif

// ### common/aie_pkg.sv
`include "aie_defs.svh"

package aie_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef logic [`AIE_NUM_IN-1:0] aie_vec_t;
    typedef logic [31:0]            aie_word_t;
    typedef enum logic {AIE_BUS_IDLE, AIE_BUS_ACCESS} aie_bus_st_t;

    // Bits of input enable registers present on a package variant
    function automatic aie_vec_t aie_ien_mask(input int pins);
        aie_vec_t m;
        m = '1;
        if (pins <= 64) begin
            m[31:19] = '0;
            m[42:32] = '0;
        end else if (pins <= 100) begin
            m[42:35] = '0;
        end
        return m;
    endfunction

    // Bits of early status registers present on a package variant
    function automatic aie_vec_t aie_est_mask(input int pins);
        aie_vec_t m;
        m = '1;
        if (pins <= 64) begin
            m[31:19] = '0;
            m[44:32] = '0;
        end else if (pins <= 100) begin
            m[44:35] = '0;
        end
        return m;
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic aie_word_t aie_merge(input aie_word_t old_w, input aie_word_t new_w,
                                            input logic [3:0] strb);
        aie_word_t r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// ### common/aie_evt_if.sv
`timescale 1ns/1ps
`include "aie_defs.svh"

// Early flag events and state between the top and the flag store
interface aie_evt_if;
    logic [`AIE_NUM_IN-1:0] set_ev;
    logic [`AIE_NUM_IN-1:0] clr_ev;
    logic [`AIE_NUM_IN-1:0] flags;

    modport src  (output set_ev, output clr_ev, input flags);
    modport sink (input set_ev, input clr_ev, output flags);
endinterface

// ### src/aie_early_flags.sv
`timescale 1ns/1ps
`include "aie_defs.svh"

module aie_early_flags
    import aie_pkg::*;
#(
    parameter aie_vec_t PRESENT = '1
) (
    // Clock and reset
    input wire logic   pclk,
    input wire logic   presetn,
    // Event side
    aie_evt_if.sink    ev
);
    import aie_pkg::*;

    aie_vec_t flag_q;
    aie_vec_t next_flag;

    // ------------------------------------------------------------------------
    // Flag update, set beats clear, absent inputs stay zero
    // ------------------------------------------------------------------------
    always_comb begin
        next_flag = ((flag_q & ~ev.clr_ev) | ev.set_ev) & PRESENT; // [R3] [R8]
    end

    // Flag registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= '0; // [R3]
        end else begin
            flag_q <= next_flag;
        end
    end

    assign ev.flags = flag_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        (|(ev.set_ev & ev.clr_ev & PRESENT)) |=>
            ((flag_q & $past(ev.set_ev & ev.clr_ev & PRESENT))
             == $past(ev.set_ev & ev.clr_ev & PRESENT)))
        else $error("early flag lost when set and clear coincide");

endmodule // aie_early_flags

// ### src/aie_top.sv
`timescale 1ns/1ps
`include "aie_defs.svh"

// What this block does
// R1: Result ready plus enable raises input interrupt
// R2: High registers bits 31..13 read zero
// R3: Early flag hardware set, hardware cleared, read-only
// R4: Early flag interrupts only with early enable
// R5: Class 1 inputs time flag by own select
// R6: Shared inputs time flag by shared select
// R7: Higher inputs exist only on larger packages, except input enable bits 43 and 44
// R8: Absent inputs read zero, ignore writes
module aie_top
    import aie_pkg::*;
#(
    parameter int       PKG_PINS    = 144,
    parameter aie_vec_t CLASS1_MASK = 45'h0000_0000_003f
) (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [`AIE_ADDR_W-1:0]     paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Converter status
    input  wire aie_pkg::aie_vec_t          result_ready_flag,
    input  wire aie_pkg::aie_vec_t          conv_active,
    input  wire aie_pkg::aie_vec_t          result_read,
    input  wire logic [`AIE_SEL_W-1:0]      class1_stage,
    input  wire logic [`AIE_SEL_W-1:0]      shared_stage,
    // Interrupt requests per input
    output aie_pkg::aie_vec_t               input_irq,
    output aie_pkg::aie_vec_t               early_irq
);
    import aie_pkg::*;

    localparam aie_vec_t IEN_MASK = aie_ien_mask(PKG_PINS);
    localparam aie_vec_t EST_MASK = aie_est_mask(PKG_PINS);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    aie_bus_st_t            bus_st;
    aie_bus_st_t            next_bus_st;
    aie_vec_t               input_irq_enable_bit;
    aie_vec_t               next_ien;
    aie_vec_t               early_irq_enable;
    aie_vec_t               next_eien;
    logic [`AIE_SEL_W-1:0]  sel_class1;
    logic [`AIE_SEL_W-1:0]  next_sel_class1;
    logic [`AIE_SEL_W-1:0]  sel_shared;
    logic [`AIE_SEL_W-1:0]  next_sel_shared;
    logic [31:0]            next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;
    aie_vec_t               next_input_irq;
    aie_vec_t               next_early_irq;
    aie_vec_t               set_class1;
    aie_vec_t               set_shared;
    aie_vec_t               early_ready_flag;
    logic                   hit;
    logic [31:0]            rd_word;
    logic                   wr_en;
    aie_word_t              ien_hi_merged;
    aie_word_t              eien_hi_merged;

    aie_evt_if ev ();

    // ------------------------------------------------------------------------
    // Early flag store
    // ------------------------------------------------------------------------
    aie_early_flags #(
        .PRESENT (EST_MASK)
    ) u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .ev      (ev.sink)
    );

    assign early_ready_flag = ev.flags;

    // Early event timing by converter class
    always_comb begin
        set_class1 = conv_active & CLASS1_MASK &
                     {`AIE_NUM_IN{class1_stage == sel_class1}}; // [R5]
        set_shared = conv_active & ~CLASS1_MASK &
                     {`AIE_NUM_IN{shared_stage == sel_shared}}; // [R6]
    end

    assign ev.set_ev = set_class1 | set_shared; // [R3]
    assign ev.clr_ev = result_read;             // [R3]

    // ------------------------------------------------------------------------
    // APB decode and read mux
    // ------------------------------------------------------------------------
    always_comb begin
        hit     = 1'b1;
        rd_word = `AIE_RST_WORD;
        case (paddr)
            `AIE_OFF_IEN_LO: begin
                rd_word = input_irq_enable_bit[31:0];
            end
            `AIE_OFF_IEN_HI: begin
                rd_word[`AIE_HI_BITS-1:0] = input_irq_enable_bit[44:32]; // [R2]
            end
            `AIE_OFF_EST_LO: begin
                rd_word = early_ready_flag[31:0];
            end
            `AIE_OFF_EST_HI: begin
                rd_word[`AIE_HI_BITS-1:0] = early_ready_flag[44:32]; // [R2]
            end
            `AIE_OFF_EIEN_LO: begin
                rd_word = early_irq_enable[31:0];
            end
            `AIE_OFF_EIEN_HI: begin
                rd_word[`AIE_HI_BITS-1:0] = early_irq_enable[44:32];
            end
            `AIE_OFF_EISEL: begin
                rd_word[`AIE_SEL_C1_LSB +: `AIE_SEL_W] = sel_class1;
                rd_word[`AIE_SEL_SH_LSB +: `AIE_SEL_W] = sel_shared;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    assign wr_en = psel && penable && pready && pwrite && hit;

    // Byte-lane merge of the high enable words, cut to the implemented bits later
    assign ien_hi_merged  = aie_merge({19'h0, input_irq_enable_bit[44:32]},
                                      pwdata, pstrb);
    assign eien_hi_merged = aie_merge({19'h0, early_irq_enable[44:32]},
                                      pwdata, pstrb);

    // ------------------------------------------------------------------------
    // Bus handshake and register next values
    // ------------------------------------------------------------------------
    always_comb begin
        next_bus_st     = bus_st;
        next_pready     = 1'b0;
        next_pslverr    = 1'b0;
        next_prdata     = prdata;
        next_ien        = input_irq_enable_bit;
        next_eien       = early_irq_enable;
        next_sel_class1 = sel_class1;
        next_sel_shared = sel_shared;
        case (bus_st)
            AIE_BUS_IDLE: begin
                if (psel && !penable) begin
                    next_bus_st  = AIE_BUS_ACCESS;
                    next_pready  = 1'b1;
                    next_pslverr = !hit;
                    next_prdata  = (pwrite || !hit) ? `AIE_RST_WORD : rd_word;
                end
            end
            AIE_BUS_ACCESS: begin
                next_bus_st = AIE_BUS_IDLE;
            end
            default: begin
                next_bus_st = AIE_BUS_IDLE;
            end
        endcase
        if (wr_en) begin
            case (paddr)
                `AIE_OFF_IEN_LO: begin
                    next_ien[31:0] = aie_merge(input_irq_enable_bit[31:0], pwdata, pstrb);
                end
                `AIE_OFF_IEN_HI: begin
                    next_ien[44:32] = ien_hi_merged[`AIE_HI_BITS-1:0]; // [R2]
                end
                `AIE_OFF_EIEN_LO: begin
                    next_eien[31:0] = aie_merge(early_irq_enable[31:0], pwdata, pstrb);
                end
                `AIE_OFF_EIEN_HI: begin
                    next_eien[44:32] = eien_hi_merged[`AIE_HI_BITS-1:0];
                end
                `AIE_OFF_EISEL: begin
                    if (pstrb[0]) begin
                        next_sel_class1 = pwdata[`AIE_SEL_C1_LSB +: `AIE_SEL_W];
                        next_sel_shared = pwdata[`AIE_SEL_SH_LSB +: `AIE_SEL_W];
                    end
                end
                default: begin
                    next_ien = input_irq_enable_bit;
                end
            endcase
        end
        next_ien  = next_ien & IEN_MASK;  // [R7] [R8]
        next_eien = next_eien & EST_MASK; // [R8]
    end

    // ------------------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------------------
    always_comb begin
        next_input_irq = result_ready_flag & input_irq_enable_bit; // [R1]
        next_early_irq = early_ready_flag & early_irq_enable;      // [R4]
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_st               <= AIE_BUS_IDLE;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
            prdata               <= `AIE_RST_WORD;
            input_irq_enable_bit <= '0;
            early_irq_enable     <= '0;
            sel_class1           <= `AIE_RST_SEL;
            sel_shared           <= `AIE_RST_SEL;
            input_irq            <= '0;
            early_irq            <= '0;
        end else begin
            bus_st               <= next_bus_st;
            pready               <= next_pready;
            pslverr              <= next_pslverr;
            prdata               <= next_prdata;
            input_irq_enable_bit <= next_ien;
            early_irq_enable     <= next_eien;
            sel_class1           <= next_sel_class1;
            sel_shared           <= next_sel_shared;
            input_irq            <= next_input_irq;
            early_irq            <= next_early_irq;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_input_irq_gate: assert property ( // [R1]
        ##1 input_irq == ($past(result_ready_flag) & $past(input_irq_enable_bit)))
        else $error("input interrupt not gated by its enable");

    chk_high_reads_zero: assert property ( // [R2]
        (psel && penable && pready && !pwrite &&
         (paddr == `AIE_OFF_IEN_HI || paddr == `AIE_OFF_EST_HI ||
          paddr == `AIE_OFF_EIEN_HI)) |-> (prdata[31:13] == 19'h0))
        else $error("unimplemented high bits read nonzero");

    chk_flag_set: assert property ( // [R3]
        (|(ev.set_ev & EST_MASK)) |=>
            ((early_ready_flag & $past(ev.set_ev & EST_MASK)) == $past(ev.set_ev & EST_MASK)))
        else $error("early flag did not set on its event");

    chk_flag_readonly: assert property ( // [R3]
        (wr_en && (ev.set_ev == '0) && (ev.clr_ev == '0)) |=> $stable(early_ready_flag))
        else $error("software write changed early flags");

    chk_early_irq_gate: assert property ( // [R4]
        ##1 early_irq == ($past(early_ready_flag) & $past(early_irq_enable)))
        else $error("early interrupt not gated by early enable");

    chk_class1_timing: assert property ( // [R5]
        (|(set_class1 & EST_MASK)) |=> ((early_ready_flag & $past(set_class1 & EST_MASK))
                                          == $past(set_class1 & EST_MASK)))
        else $error("class 1 flag missed its select stage");

    chk_shared_timing: assert property ( // [R6]
        (|(conv_active & ~CLASS1_MASK & EST_MASK) && shared_stage != sel_shared &&
         ev.set_ev == '0 && early_ready_flag == '0) |=> (early_ready_flag == '0))
        else $error("shared flag set away from its select stage");

    chk_variant_absent: assert property ( // [R7]
        ((early_ready_flag & ~EST_MASK) == '0) && ((input_irq & ~IEN_MASK) == '0))
        else $error("absent input shows a flag or interrupt");

    chk_absent_write: assert property ( // [R8]
        wr_en |=> (((input_irq_enable_bit & ~IEN_MASK) == '0) &&
                   ((early_irq_enable & ~EST_MASK) == '0)))
        else $error("write reached an absent input bit");

    // Bus handshake checks
    chk_pready_single: assert property (
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    chk_unmapped_error: assert property (
        (bus_st == AIE_BUS_IDLE && psel && !penable && !hit) |=>
            (pready && pslverr && prdata == '0))
        else $error("unmapped access not answered with error");

    chk_bus_idle_quiet: assert property (
        !psel |=> (!pready && !pslverr))
        else $error("ready raised without a selected transfer");

    cov_early_flag: cover property (|early_ready_flag ##1 early_ready_flag == '0);
    cov_early_irq: cover property (|early_irq);
    cov_input_irq: cover property (|input_irq);
    cov_bad_addr: cover property (pready && pslverr);
    cov_set_and_clear: cover property (|(ev.set_ev & ev.clr_ev));

endmodule // aie_top

// ### dv/tb_aie_top.sv
`timescale 1ns/1ps
`include "aie_defs.svh"

// ----------------------------------------------------------------------------
// Compare helper
// ----------------------------------------------------------------------------
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_aie_top;
    import aie_pkg::*;

    typedef struct {
        logic [7:0] a;
        aie_word_t  w;
        aie_word_t  e;
        logic       er;
        aie_word_t  e64;
    } aie_tb_row_t;

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [3:0]            pstrb;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    aie_vec_t              result_ready_flag;
    aie_vec_t              conv_active;
    aie_vec_t              result_read;
    logic [2:0]            class1_stage;
    logic [2:0]            shared_stage;
    aie_vec_t              input_irq;
    aie_vec_t              early_irq;
    int                    err_total;
    int                    samples_checked;
    aie_tb_row_t           rows [8];
    aie_word_t             rd;
    logic                  er;
    logic [31:0]           prdata64;
    aie_vec_t              input_irq64;
    aie_word_t             rd64;

    aie_top aie_top_i (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .pstrb             (pstrb),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .result_ready_flag (result_ready_flag),
        .conv_active       (conv_active),
        .result_read       (result_read),
        .class1_stage      (class1_stage),
        .shared_stage      (shared_stage),
        .input_irq         (input_irq),
        .early_irq         (early_irq)
    );

    // Smallest package variant on the same bus, for the absent inputs
    aie_top #(
        .PKG_PINS          (64)
    ) aie_top_pins64_i (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .pstrb             (pstrb),
        .prdata            (prdata64),
        .pready            (),
        .pslverr           (),
        .result_ready_flag (result_ready_flag),
        .conv_active       (conv_active),
        .result_read       (result_read),
        .class1_stage      (class1_stage),
        .shared_stage      (shared_stage),
        .input_irq         (input_irq64),
        .early_irq         ()
    );

    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------------
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input aie_word_t d,
                       output aie_word_t r, output logic e);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!(pready === 1'b1) && n < 20);
        if (n >= 20) begin
            err_total++;
        end
        r = prdata;
        e = pslverr;
        rd64 = prdata64;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input aie_word_t e, input string nm);
        apb(1'b0, a, 32'h0000_0000, rd, er);
        `CHK(nm, e, rd)
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #50000;
        err_total++;
        summarize();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        err_total = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        result_ready_flag = '0;
        conv_active = '0;
        result_read = '0;
        class1_stage = 3'h0;
        shared_stage = 3'h0;
        rows = '{'{8'h00, 32'hffff_ffff, 32'hffff_ffff, 1'b0, 32'h0007_ffff},
                 '{8'h04, 32'hffff_ffff, 32'h0000_1fff, 1'b0, 32'h0000_1800},
                 '{8'h08, 32'hffff_ffff, 32'h0000_0000, 1'b0, 32'h0000_0000},
                 '{8'h0c, 32'hffff_ffff, 32'h0000_0000, 1'b0, 32'h0000_0000},
                 '{8'h10, 32'hffff_ffff, 32'hffff_ffff, 1'b0, 32'h0007_ffff},
                 '{8'h14, 32'hffff_ffff, 32'h0000_1fff, 1'b0, 32'h0000_0000},
                 '{8'h18, 32'h0000_0053, 32'h0000_0053, 1'b0, 32'h0000_0053},
                 '{8'h1c, 32'h1234_5678, 32'h0000_0000, 1'b1, 32'h0000_0000}};
        cycles(6);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values of every register
        for (int i = 0; i < 7; i++) begin
            rd_chk(rows[i].a, 32'h0000_0000, "reset value");
        end
        // Write then read back each place
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, rows[i].a, rows[i].w, rd, er);
            `CHK("error flag", rows[i].er, er)
            rd_chk(rows[i].a, rows[i].e, "readback");
            `CHK("readback 64 pins", rows[i].e64, rd64)
        end
        // Result ready gated by enables, low and high words
        apb(1'b1, 8'h00, 32'h0000_0020, rd, er);
        apb(1'b1, 8'h04, 32'h0000_0100, rd, er);
        result_ready_flag <= 45'h130_0000_0060;
        cycles(3);
        `CHK("input irq", 45'h100_0000_0020, input_irq)
        `CHK("input irq 64 pins", 45'h000_0000_0020, input_irq64)
        result_ready_flag <= '0;
        cycles(3);
        `CHK("input irq off", 45'h000_0000_0000, input_irq)
        // Early events: class 1 input 2, shared inputs 10 and 40
        apb(1'b1, 8'h10, 32'h0000_0004, rd, er);
        apb(1'b1, 8'h14, 32'h0000_0000, rd, er);
        conv_active  <= 45'h100_0000_0404;
        class1_stage <= 3'h3;
        shared_stage <= 3'h4;
        @(posedge pclk);
        class1_stage <= 3'h0;
        shared_stage <= 3'h5;
        @(posedge pclk);
        conv_active  <= '0;
        cycles(3);
        rd_chk(8'h08, 32'h0000_0404, "early status low");
        rd_chk(8'h0c, 32'h0000_0100, "early status high");
        `CHK("early irq", 45'h000_0000_0004, early_irq)
        // Hardware clear of flag 2
        result_read <= 45'h000_0000_0004;
        @(posedge pclk);
        result_read <= '0;
        cycles(3);
        rd_chk(8'h08, 32'h0000_0400, "cleared status");
        `CHK("early irq cleared", 45'h000_0000_0000, early_irq)
        // Event and clear of flag 2 in one cycle: set wins
        conv_active  <= 45'h000_0000_0004;
        class1_stage <= 3'h3;
        result_read  <= 45'h000_0000_0004;
        @(posedge pclk);
        conv_active  <= '0;
        class1_stage <= 3'h0;
        result_read  <= '0;
        cycles(2);
        rd_chk(8'h08, 32'h0000_0404, "set beats clear");
        `CHK("early irq again", 45'h000_0000_0004, early_irq)
        // Second reset in mid-run with an interrupt standing
        result_ready_flag <= 45'h000_0000_0020;
        cycles(2);
        `CHK("irq before reset", 45'h000_0000_0020, input_irq)
        presetn <= 1'b0;
        cycles(2);
        `CHK("irq in reset", 45'h000_0000_0000, input_irq)
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("irq after reset", 45'h000_0000_0000, input_irq)
        rd_chk(8'h00, 32'h0000_0000, "enable after reset");
        rd_chk(8'h0c, 32'h0000_0000, "status after reset");
        // Shared input active away from its select stage
        result_ready_flag <= '0;
        conv_active  <= 45'h000_0000_0400;
        shared_stage <= 3'h1;
        cycles(2);
        conv_active  <= '0;
        shared_stage <= 3'h0;
        rd_chk(8'h08, 32'h0000_0000, "shared off stage");
        summarize();
    end
endmodule // tb_aie_top
